// file: core/nvsh_cfg.svh
// timing and address constants for the nonvolatile sram host controller
`ifndef NVSH_CFG_SVH
`define NVSH_CFG_SVH
`define NVSH_ADDR_W      17
`define NVSH_DATA_W      16
`define NVSH_SEQ0        17'h04e38
`define NVSH_SEQ1        17'h0b1c7
`define NVSH_SEQ2        17'h083e0
`define NVSH_SEQ3        17'h07c1f
`define NVSH_SEQ4        17'h0703f
`define NVSH_SEQ_STORE   17'h08fc0
`define NVSH_SEQ_RECALL  17'h04c63
`define NVSH_SEQ_ASDIS   17'h08b45
`define NVSH_SEQ_ASEN    17'h04b46
`define NVSH_SEQ_LAST    3'h5
`define NVSH_ACC_NS      45
`define NVSH_CLK_NS      5
`define NVSH_ACC_CYC     ((`NVSH_ACC_NS + `NVSH_CLK_NS - 1) / `NVSH_CLK_NS)
`define NVSH_PULSE_NS    20
`define NVSH_PULSE_CYC   ((`NVSH_PULSE_NS + `NVSH_CLK_NS - 1) / `NVSH_CLK_NS)
`define NVSH_CNT_W       8
`endif

// file: core/nvsh_pkg.sv
// types for the nonvolatile sram host controller
`default_nettype none
package nvsh_pkg;
    // request kinds issued by the user side
    typedef enum logic [2:0] {
        NVSH_OP_READ    = 3'h0,
        NVSH_OP_WRITE   = 3'h1,
        NVSH_OP_STORE   = 3'h2,
        NVSH_OP_RECALL  = 3'h3,
        NVSH_OP_ASDIS   = 3'h4,
        NVSH_OP_ASEN    = 3'h5,
        NVSH_OP_HWSTORE = 3'h6
    } nvsh_op_t;

    typedef struct packed {
        nvsh_op_t    op;
        logic [16:0] addr;
        logic [15:0] wdata;
        logic [1:0]  be;
    } nvsh_req_t;

    // strobes driven onto the memory pins, active low
    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        upper_byte_enable_n;
        logic        lower_byte_enable_n;
        logic [16:0] addr;
    } nvsh_pins_t;
endpackage : nvsh_pkg
`default_nettype wire

// file: core/nvsh_sync.sv
// three stage input synchroniser for the store-busy pin
`timescale 1ns/1ps
`default_nettype none
module nvsh_sync (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic [2:0] sh_reg;
    logic [2:0] sh_next;
    logic       q_reg;
    logic       q_next;

    always_comb begin
        sh_next = {sh_reg[1:0], d_i};
        // change counts only when the second and third stages agree
        q_next  = (sh_reg[1] == sh_reg[2]) ? sh_reg[2] : q_reg;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sh_reg <= 3'h7;
            q_reg  <= 1'b1;
        end else begin
            sh_reg <= sh_next;
            q_reg  <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule : nvsh_sync
`default_nettype wire

// file: core/nvsh_host.sv
// host controller driving an asynchronous nonvolatile sram port
`timescale 1ns/1ps
`default_nettype none
`include "nvsh_cfg.svh"
module nvsh_host #(
    parameter int ACC_CYC = `NVSH_ACC_CYC,
    parameter int BUSY_TO = 4000
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               req_valid_i,
    output logic                    req_ready_o,
    input  wire nvsh_pkg::nvsh_req_t req_i,
    output logic                    rsp_valid_o,
    output logic [15:0]             rsp_rdata_o,
    output logic                    busy_o,
    output logic                    timeout_o,
    output nvsh_pkg::nvsh_pins_t    pins_o,
    input  wire logic [15:0]        dq_i,
    output logic [15:0]             dq_o,
    output logic                    dq_oe_n_o,
    input  wire logic               store_busy_n_i,
    output logic                    store_busy_n_o,
    output logic                    store_busy_oe_n_o
);
    import nvsh_pkg::*;

    // ==========================================================
    // state
    // ==========================================================
    typedef enum logic [2:0] {
        NVSH_IDLE  = 3'b000,
        NVSH_SETUP = 3'b001,
        NVSH_STRB  = 3'b011,
        NVSH_HOLD  = 3'b010,
        NVSH_WAIT  = 3'b110,
        NVSH_HWREQ = 3'b111
    } nvsh_state_t;

    nvsh_state_t         st_reg, st_next;
    nvsh_req_t           rq_reg, rq_next;
    nvsh_pins_t          pin_reg, pin_next;
    logic [15:0]         dq_reg, dq_next;
    logic                dqoe_reg, dqoe_next;
    logic [15:0]         rd_reg, rd_next;
    logic                rv_reg, rv_next;
    logic [2:0]          idx_reg, idx_next;
    logic [15:0]         cnt_reg, cnt_next;
    logic                to_reg, to_next;
    logic                hsb_reg, hsb_next;
    logic                busy_s;
    logic [16:0]         seq_addr;
    logic                is_seq;

    nvsh_sync u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (store_busy_n_i),
        .q_o   (busy_s)
    );

    // sequence ops issue six reads; the sixth address picks the operation
    assign is_seq = (rq_reg.op == NVSH_OP_STORE) || (rq_reg.op == NVSH_OP_RECALL)
                 || (rq_reg.op == NVSH_OP_ASDIS) || (rq_reg.op == NVSH_OP_ASEN);

    always_comb begin
        unique case (idx_reg)
            3'h0: seq_addr = `NVSH_SEQ0;
            3'h1: seq_addr = `NVSH_SEQ1;
            3'h2: seq_addr = `NVSH_SEQ2;
            3'h3: seq_addr = `NVSH_SEQ3;
            3'h4: seq_addr = `NVSH_SEQ4;
            default: begin
                unique case (rq_reg.op)
                    NVSH_OP_RECALL: seq_addr = `NVSH_SEQ_RECALL;
                    NVSH_OP_ASDIS:  seq_addr = `NVSH_SEQ_ASDIS;
                    NVSH_OP_ASEN:   seq_addr = `NVSH_SEQ_ASEN;
                    default:        seq_addr = `NVSH_SEQ_STORE;
                endcase
            end
        endcase
    end

    // ==========================================================
    // sequencer
    // ==========================================================
    always_comb begin
        st_next   = st_reg;
        rq_next   = rq_reg;
        pin_next  = pin_reg;
        dq_next   = dq_reg;
        dqoe_next = dqoe_reg;
        rd_next   = rd_reg;
        rv_next   = 1'b0;
        idx_next  = idx_reg;
        cnt_next  = cnt_reg;
        to_next   = 1'b0;
        hsb_next  = 1'b1;
        unique case (st_reg)
            NVSH_IDLE: begin
                pin_next.ce_n = 1'b1;
                pin_next.oe_n = 1'b1;
                pin_next.we_n = 1'b1;
                dqoe_next     = 1'b1;
                // no access while the device is busy storing or recalling
                if (req_valid_i && busy_s) begin
                    rq_next  = req_i;
                    idx_next = 3'h0;
                    cnt_next = 16'h0;
                    if (req_i.op == NVSH_OP_HWSTORE) begin
                        st_next = NVSH_HWREQ;
                    end else begin
                        st_next = NVSH_SETUP;
                    end
                end
            end
            NVSH_SETUP: begin
                // address settles before any strobe falls
                pin_next.addr = is_seq ? seq_addr : rq_reg.addr;
                pin_next.upper_byte_enable_n = is_seq ? 1'b0 : ~rq_reg.be[1];
                pin_next.lower_byte_enable_n = is_seq ? 1'b0 : ~rq_reg.be[0];
                dq_next  = rq_reg.wdata;
                cnt_next = 16'h0;
                st_next  = NVSH_STRB;
            end
            NVSH_STRB: begin
                pin_next.ce_n = 1'b0;
                if (rq_reg.op == NVSH_OP_WRITE) begin
                    pin_next.oe_n = 1'b1;
                    pin_next.we_n = 1'b0;
                    dqoe_next     = 1'b0;
                end else begin
                    pin_next.oe_n = 1'b0;
                    pin_next.we_n = 1'b1;
                end
                cnt_next = cnt_reg + 16'h1;
                if (cnt_reg == 16'(ACC_CYC)) begin
                    if (rq_reg.op != NVSH_OP_WRITE) begin
                        rd_next = dq_i;
                    end
                    st_next = NVSH_HOLD;
                end
            end
            NVSH_HOLD: begin
                // rising we ends the write with data and address still held
                pin_next.ce_n = 1'b1;
                pin_next.oe_n = 1'b1;
                pin_next.we_n = 1'b1;
                cnt_next = 16'h0;
                if (is_seq && idx_reg != `NVSH_SEQ_LAST) begin
                    idx_next = idx_reg + 3'h1;
                    st_next  = NVSH_SETUP;
                end else if (is_seq) begin
                    st_next = NVSH_WAIT;
                end else begin
                    rv_next = 1'b1;
                    st_next = NVSH_IDLE;
                end
            end
            NVSH_WAIT: begin
                dqoe_next = 1'b1;
                cnt_next  = cnt_reg + 16'h1;
                // give the device time to pull busy low, then wait for release
                if (cnt_reg > 16'(`NVSH_PULSE_CYC) && busy_s) begin
                    rv_next = 1'b1;
                    st_next = NVSH_IDLE;
                end else if (cnt_reg == 16'(BUSY_TO)) begin
                    to_next = 1'b1;
                    rv_next = 1'b1;
                    st_next = NVSH_IDLE;
                end
            end
            NVSH_HWREQ: begin
                // pull busy low for a pulse then let the device hold it
                hsb_next = (cnt_reg < 16'(`NVSH_PULSE_CYC)) ? 1'b0 : 1'b1;
                cnt_next = cnt_reg + 16'h1;
                if (cnt_reg >= 16'(`NVSH_PULSE_CYC)) begin
                    cnt_next = 16'h0;
                    st_next  = NVSH_WAIT;
                end
            end
            default: st_next = NVSH_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg   <= NVSH_IDLE;
            rq_reg   <= '0;
            pin_reg  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                          upper_byte_enable_n: 1'b1, lower_byte_enable_n: 1'b1,
                          addr: 17'h0};
            dq_reg   <= 16'h0;
            dqoe_reg <= 1'b1;
            rd_reg   <= 16'h0;
            rv_reg   <= 1'b0;
            idx_reg  <= 3'h0;
            cnt_reg  <= 16'h0;
            to_reg   <= 1'b0;
            hsb_reg  <= 1'b1;
        end else begin
            st_reg   <= st_next;
            rq_reg   <= rq_next;
            pin_reg  <= pin_next;
            dq_reg   <= dq_next;
            dqoe_reg <= dqoe_next;
            rd_reg   <= rd_next;
            rv_reg   <= rv_next;
            idx_reg  <= idx_next;
            cnt_reg  <= cnt_next;
            to_reg   <= to_next;
            hsb_reg  <= hsb_next;
        end
    end

    assign req_ready_o       = (st_reg == NVSH_IDLE) && busy_s;
    assign rsp_valid_o       = rv_reg;
    assign rsp_rdata_o       = rd_reg;
    assign busy_o            = ~busy_s;
    assign timeout_o         = to_reg;
    assign pins_o            = pin_reg;
    assign dq_o              = dq_reg;
    assign dq_oe_n_o         = dqoe_reg;
    assign store_busy_n_o    = 1'b0;
    assign store_busy_oe_n_o = hsb_reg;

    // ==========================================================
    // checks
    // ==========================================================
    no_contend_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !dqoe_reg |-> pins_o.oe_n) else $error("bus driven while oe low");
    we_oe_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !pins_o.we_n |-> !pins_o.ce_n && pins_o.oe_n) else $error("bad write strobes");
    addr_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !pins_o.ce_n |=> $stable(pins_o.addr)) else $error("address moved in cycle");
    idle_deselect_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg == NVSH_IDLE |=> pins_o.ce_n) else $error("selected while idle");
    busy_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_reg == NVSH_IDLE && !busy_s) |=> st_reg == NVSH_IDLE)
        else $error("access started while busy");
    seq_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_reg == NVSH_STRB && is_seq && idx_reg == 3'h0) |-> pins_o.addr == `NVSH_SEQ0)
        else $error("sequence start address wrong");
    rd_strb_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_reg == NVSH_SETUP && rq_reg.op == NVSH_OP_READ) |=> ##1 !pins_o.oe_n && pins_o.we_n)
        else $error("read strobes wrong");
    hw_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(st_reg == NVSH_HWREQ) |=> !store_busy_oe_n_o) else $error("no store pulse");
    c_read: cover property (@(posedge clk_i) rv_reg && rq_reg.op == NVSH_OP_READ);
    c_write: cover property (@(posedge clk_i) rv_reg && rq_reg.op == NVSH_OP_WRITE);
    c_store: cover property (@(posedge clk_i) rv_reg && rq_reg.op == NVSH_OP_STORE);
    c_hw: cover property (@(posedge clk_i) rv_reg && rq_reg.op == NVSH_OP_HWSTORE);
endmodule : nvsh_host
`default_nettype wire

// file: sim/nvsh_dev_model.sv
// behavioural model of the nonvolatile sram device facing the host
`timescale 1ns/1ps
`default_nettype none
`include "nvsh_cfg.svh"
module nvsh_dev_model #(
    parameter int XFER_CYC = 20,
    parameter int HI_CYC   = 2
) (
    input  wire logic                 clk_i,
    input  wire nvsh_pkg::nvsh_pins_t pins_i,
    input  wire logic [15:0]          dq_i,
    input  wire logic                 hsb_i,
    input  wire logic                 pwr_fail_i,
    output logic [15:0]               dq_o,
    output logic [1:0]                dq_en_o,
    output logic                      hsb_lo_o,
    output logic                      hsb_hi_o
);
    import nvsh_pkg::*;
    localparam logic [16:0] SEQ [5] = '{`NVSH_SEQ0, `NVSH_SEQ1, `NVSH_SEQ2, `NVSH_SEQ3, `NVSH_SEQ4};
    logic [15:0] mem [0:65535];
    logic [15:0] nv  [0:65535];
    int          bcnt = 0, hcnt = 0, idx = 0, n_store = 0, n_recall = 0;
    logic        wp = 0, as_en = 1, wr_act = 0, rd = 0, rd_q = 0;
    logic        pf_q = 0, go_st = 0, go_rc = 0, rc_pend = 0;
    logic [16:0] wa;
    logic [15:0] wd;
    logic [1:0]  wl;
    initial for (int i = 0; i < 65536; i++) begin
        mem[i] = 16'h0;
        nv[i]  = 16'h0;
    end
    assign hsb_lo_o = (bcnt > 0);
    assign hsb_hi_o = (hcnt > 0);
    always_comb begin
        dq_o    = mem[pins_i.addr[15:0]];
        dq_en_o = 2'h0;
        if (!pins_i.ce_n && !pins_i.oe_n && pins_i.we_n && hsb_i && !hsb_lo_o)
            dq_en_o = ~{pins_i.upper_byte_enable_n, pins_i.lower_byte_enable_n};
    end
    always @(pins_i or dq_i or hsb_i) begin
        if (!pins_i.ce_n && !pins_i.we_n && hsb_i && !hsb_lo_o) begin
            wr_act = 1;
            wa = pins_i.addr;
            wd = dq_i;
            wl = ~{pins_i.upper_byte_enable_n, pins_i.lower_byte_enable_n};
        end else if (wr_act) begin
            wr_act = 0;
            wp = 1;
            idx = 0;
            if (wl[1]) mem[wa[15:0]][15:8] = wd[15:8];
            if (wl[0]) mem[wa[15:0]][7:0] = wd[7:0];
        end
        rd = !pins_i.ce_n && !pins_i.oe_n && pins_i.we_n && hsb_i && !hsb_lo_o;
        if (rd && !rd_q) begin
            if (idx == 5) begin
                go_st = (pins_i.addr == `NVSH_SEQ_STORE);
                go_rc = (pins_i.addr == `NVSH_SEQ_RECALL);
                if (pins_i.addr == `NVSH_SEQ_ASDIS) as_en = 0;
                if (pins_i.addr == `NVSH_SEQ_ASEN) as_en = 1;
                idx = 0;
            end else if (pins_i.addr == SEQ[idx]) idx = idx + 1;
            else idx = (pins_i.addr == SEQ[0]) ? 1 : 0;
        end
        rd_q = rd;
    end
    // a whole-array copy stands for the parallel transfer of every cell
    always @(posedge clk_i) begin
        if (hcnt > 0) hcnt = hcnt - 1;
        if (bcnt > 0) begin
            bcnt = bcnt - 1;
            if (bcnt == 0) hcnt = HI_CYC;
        end else if (go_st || (!hsb_i && hcnt == 0 && wp)
                     || (pwr_fail_i && !pf_q && as_en && wp)) begin
            go_st = 0;
            nv = mem;
            wp = 0;
            n_store++;
            bcnt = XFER_CYC;
        end else if (go_rc || (rc_pend && !pwr_fail_i)) begin
            go_rc = 0;
            rc_pend = 0;
            mem = nv;
            wp = 0;
            n_recall++;
            bcnt = XFER_CYC;
        end
        if (pwr_fail_i && !pf_q) rc_pend = 1;
        pf_q = pwr_fail_i;
    end
endmodule : nvsh_dev_model
`default_nettype wire

// file: sim/test_nvsh_host.sv
// self-checking bench for the nonvolatile sram host controller
`timescale 1ns/1ps
`default_nettype none
module test_nvsh_host;
    import nvsh_pkg::*;
    logic        clk_i = 0, rst_i = 1, req_valid_i = 0, pwr_fail = 0, saw_busy = 0;
    nvsh_req_t   req_i = '0;
    nvsh_pins_t  pins_o;
    logic        req_ready_o, rsp_valid_o, busy_o, timeout_o, dq_oe_n_o;
    logic        store_busy_n_o, store_busy_oe_n_o, dev_lo;
    logic [15:0] rsp_rdata_o, dq_o, dev_dq, rd, flt = 16'h5a5a;
    logic [1:0]  dev_en;
    wire logic [15:0] dq;
    wire logic   store_busy_n;
    int          n_fail = 0, check_count = 0;
    logic [15:0] bm [int], bnv [int];
    logic [15:0] addrs [$];
    // released lanes show a pattern that changes every cycle
    assign dq = {!dq_oe_n_o ? dq_o[15:8] : dev_en[1] ? dev_dq[15:8] : flt[15:8],
                 !dq_oe_n_o ? dq_o[7:0] : dev_en[0] ? dev_dq[7:0] : flt[7:0]};
    assign store_busy_n = ((!store_busy_oe_n_o && !store_busy_n_o) || dev_lo) ? 1'b0 : 1'b1;
    always @(posedge clk_i) flt <= ~flt;
    always @(negedge clk_i) if (busy_o === 1'b1) saw_busy <= 1;
    initial forever #2.5 clk_i = ~clk_i;
    nvsh_host #(.ACC_CYC(2), .BUSY_TO(200)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i),
        .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .busy_o(busy_o),
        .timeout_o(timeout_o), .pins_o(pins_o), .dq_i(dq), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o),
        .store_busy_n_i(store_busy_n), .store_busy_n_o(store_busy_n_o),
        .store_busy_oe_n_o(store_busy_oe_n_o));
    nvsh_dev_model #(.XFER_CYC(20), .HI_CYC(2)) dev_u (.clk_i(clk_i), .pins_i(pins_o),
        .dq_i(dq), .hsb_i(store_busy_n), .pwr_fail_i(pwr_fail), .dq_o(dev_dq), .dq_en_o(dev_en),
        .hsb_lo_o(dev_lo), .hsb_hi_o());
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic stall;
        chk(16'h0, 16'h1);
        results();
    endtask : stall
    task automatic op(input nvsh_op_t k, input logic [15:0] a, input logic [15:0] d,
                      input logic [1:0] be);
        int i;
        @(negedge clk_i);
        req_i = '{k, {1'b0, a}, d, be};
        req_valid_i = 1;
        for (i = 0; i < 300 && req_ready_o !== 1'b1; i++) @(negedge clk_i);
        if (i == 300) stall();
        @(negedge clk_i);
        req_valid_i = 0;
        for (i = 0; i < 400 && rsp_valid_o !== 1'b1; i++) @(negedge clk_i);
        if (i == 400) stall();
        rd = rsp_rdata_o;
        chk({15'h0, timeout_o}, 16'h0);
    endtask : op
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}};
        op(NVSH_OP_WRITE, a, d, be);
        bm[a] = ((bm.exists(a) ? bm[a] : 16'h0) & ~m) | (d & m);
    endtask : wr
    task automatic rdchk(input logic [15:0] a, input logic [1:0] be);
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}};
        op(NVSH_OP_READ, a, 16'h0, be);
        chk(rd & m, bm[a] & m);
    endtask : rdchk
    task automatic wait_busy(input logic v);
        int i;
        for (i = 0; i < 400 && busy_o !== v; i++) @(negedge clk_i);
        if (i == 400) stall();
    endtask : wait_busy
    initial begin
        void'($urandom(4));
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 0;
        chk({11'h0, pins_o.ce_n, pins_o.oe_n, pins_o.we_n, dq_oe_n_o, store_busy_oe_n_o},
            16'h1f);
        for (int i = 0; i < 12; i++) begin
            addrs.push_back(16'($urandom));
            wr(addrs[i], 16'($urandom), 2'($urandom_range(1, 3)));
        end
        foreach (addrs[i]) rdchk(addrs[i], 2'($urandom_range(1, 3)));
        op(NVSH_OP_STORE, 16'h0, 16'h0, 2'h3);
        chk(16'(dev_u.n_store), 16'h1);
        chk({15'h0, saw_busy}, 16'h1);
        bnv = bm;
        wr(addrs[0], ~bm[addrs[0]], 2'h3);
        op(NVSH_OP_RECALL, 16'h0, 16'h0, 2'h3);
        bm = bnv;
        rdchk(addrs[0], 2'h3);
        // a pin request with no write since the recall must be ignored
        op(NVSH_OP_HWSTORE, 16'h0, 16'h0, 2'h3);
        chk(16'(dev_u.n_store), 16'h1);
        wr(addrs[1], 16'h1234, 2'h3);
        op(NVSH_OP_HWSTORE, 16'h0, 16'h0, 2'h3);
        chk(16'(dev_u.n_store), 16'h2);
        bnv = bm;
        op(NVSH_OP_ASDIS, 16'h0, 16'h0, 2'h3);
        wr(addrs[2], 16'hbeef, 2'h3);
        pwr_fail = 1;
        repeat (30) @(negedge clk_i);
        chk(16'(dev_u.n_store), 16'h2);
        pwr_fail = 0;
        wait_busy(1'b1);
        wait_busy(1'b0);
        bm = bnv;
        rdchk(addrs[2], 2'h3);
        op(NVSH_OP_ASEN, 16'h0, 16'h0, 2'h3);
        wr(addrs[3], 16'h55aa, 2'h3);
        pwr_fail = 1;
        wait_busy(1'b1);
        chk({15'h0, req_ready_o}, 16'h0);
        wait_busy(1'b0);
        chk(16'(dev_u.n_store), 16'h3);
        bnv = bm;
        pwr_fail = 0;
        wait_busy(1'b1);
        wait_busy(1'b0);
        chk(16'(dev_u.n_recall), 16'h3);
        rdchk(addrs[3], 2'h3);
        results();
    end
endmodule : test_nvsh_host
`default_nettype wire
